// ### core/wac_acc_buf.sv
// circular buffer of accumulated weighing results
`timescale 1ns/10ps
`include "wac_cfg.svh"
module wac_acc_buf #(
  parameter int DEPTH = `WAC_ACC_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic push,
  input wire logic [7:0] push_code,
  input wire logic push_neg,
  input wire logic [19:0] push_bcd,
  input wire logic pop,
  output logic [7:0] head_code,
  output logic head_neg,
  output logic [19:0] head_bcd,
  output logic empty,
  output logic full
);
  import wac_pkg::*;

  // pointers are nine bits wide, so the structure serves up to 256 entries
  if (DEPTH < 2 || DEPTH > 256 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("wac_acc_buf: DEPTH must be a power of two from 2 to 256");
  end

  localparam int AW = $clog2(DEPTH);

  logic [28:0] mem [DEPTH];
  wac_buf_s q, d;
  logic do_push;
  logic do_pop;

  assign empty = (q.cnt == 10'h000);
  assign full = (q.cnt == 10'(DEPTH));
  // a full buffer drops new results rather than losing unread ones
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  assign {head_code, head_neg, head_bcd} = mem[q.rp[AW-1:0]];

  // pointer and fill level update
  always_comb begin
    d = q;
    if (do_push) begin
      d.wp = q.wp + 9'h001;
    end
    if (do_pop) begin
      d.rp = q.rp + 9'h001; // oldest entry discarded once read [RULE11]
    end
    d.cnt = q.cnt + {9'h000, do_push} - {9'h000, do_pop};
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // storage holds code number and weighing value per entry [RULE10]
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[q.wp[AW-1:0]] <= {push_code, push_neg, push_bcd};
    end
  end

  a_pop_drops_oldest: assert property (@(posedge clk) disable iff (sys_rst)
    (pop && !empty && !push) |=> q.cnt == $past(q.cnt) - 10'h001) // [RULE11]
    else $error("read of the buffer did not discard one entry");
endmodule

// ### core/wac_cfg.svh
// constant definitions for the ascii serial command interpreter
`ifndef WAC_CFG_SVH
`define WAC_CFG_SVH

// ascii characters used in framing, decoding and replies
`define WAC_CH_CR 8'h0D
`define WAC_CH_LF 8'h0A
`define WAC_CH_PLUS 8'h2B
`define WAC_CH_MINUS 8'h2D
`define WAC_CH_DOT 8'h2E
`define WAC_CH_ZERO 8'h30
`define WAC_CH_NINE 8'h39
`define WAC_CH_A 8'h41
`define WAC_CH_F 8'h46
`define WAC_CH_Z 8'h5A

// leading command letters
`define WAC_LEAD_READ 8'h52
`define WAC_LEAD_CMD 8'h43
`define WAC_LEAD_WRITE 8'h57

// second letters of read commands
`define WAC_GROSS_READ 8'h41
`define WAC_COUNT_READ 8'h48
`define WAC_ACCV_READ 8'h49
`define WAC_ACCW_READ 8'h4A

// second letters of one-shot commands with special handling
`define WAC_ZERO_CAL 8'h41
`define WAC_SPAN_CAL 8'h42
`define WAC_CLEAR_ACCUM 8'h4B

// line lengths in characters, terminator excluded; reply buffer size in characters
`define WAC_LINE_MAX 4'h8
`define WAC_LEN_SHORT 4'h2
`define WAC_LEN_SET_RD 4'h3
`define WAC_LEN_SET_WR 4'h8
`define WAC_TXB_LEN 16

// communication numbers that address per-code settings
`define WAC_PERCODE_LO 8'h20
`define WAC_PERCODE_HI 8'h2F

// largest status digit reported after calibration
`define WAC_CAL_MAX 4'h9

// accumulated weight buffer depth
`define WAC_ACC_DEPTH 256

`endif

// ### core/wac_cmd.sv
// ascii serial command interpreter of the weighing controller
//
// Functional notes
// RULE1 - gross read answers sign, five digits with decimal point, then CR LF
// RULE2 - count read echoes command, four count digits, then CR LF
// RULE3 - accumulated value read echoes command, nine digits with point, CR LF
// RULE4 - setting read answers write letter, number, five plain digits, CR LF
// RULE5 - setting write carries letter, number, five digits; stored silently
// RULE6 - one-shot action commands are performed with no reply at all
// RULE7 - zero calibration runs, then echo, one status digit and CR LF
// RULE8 - status digit zero means success, one to nine the error number
// RULE9 - host sets capacity, division and balance weight before span calibration
// RULE10 - up to 256 results kept, each code and value, given on read
// RULE11 - reading the result buffer discards its oldest entry
// RULE12 - clear command zeroes all 100 code totals, no reply
// RULE13 - host names the code number for per-code setting accesses
// RULE14 - per-code writes accepted only while per-code selection is enabled
// RULE15 - soft write lock rejects setting writes, stored values unchanged
// RULE16 - commands end in carriage return; decoding starts only then
// RULE17 - replies are ascii and end with carriage return, line feed
`timescale 1ns/10ps
`include "wac_cfg.svh"
module wac_cmd #(
  parameter int ACC_DEPTH = `WAC_ACC_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic gross_neg,
  input wire logic [19:0] gross_bcd,
  input wire logic [2:0] gross_dp,
  input wire logic [15:0] count_bcd,
  input wire logic [35:0] accv_bcd,
  input wire logic [3:0] accv_dp,
  output logic [7:0] set_rd_num,
  input wire logic [19:0] set_rd_bcd,
  output logic set_wr_en,
  output logic [7:0] set_wr_num,
  output logic [19:0] set_wr_bcd,
  input wire logic soft_lock,
  input wire logic percode_en,
  output logic act_pulse,
  output logic [7:0] act_code,
  output logic clr_pulse,
  output logic cal_start,
  output logic cal_span,
  input wire logic cal_done,
  input wire logic [3:0] cal_status,
  input wire logic acc_push,
  input wire logic [7:0] acc_push_code,
  input wire logic acc_push_neg,
  input wire logic [19:0] acc_push_bcd,
  output logic acc_full
);
  import wac_pkg::*;

  wac_core_s q, d;
  logic acc_pop;
  logic [7:0] head_code;
  logic head_neg;
  logic [19:0] head_bcd;
  logic acc_empty;

  function automatic logic [3:0] hex_val(input logic [7:0] c);
    if (c >= `WAC_CH_A) begin
      hex_val = 4'(c - 8'h37);
    end else begin
      hex_val = 4'(c - `WAC_CH_ZERO);
    end
  endfunction

  function automatic logic is_digit(input logic [7:0] c);
    is_digit = (c >= `WAC_CH_ZERO) && (c <= `WAC_CH_NINE);
  endfunction

  function automatic logic is_hex(input logic [7:0] c);
    is_hex = is_digit(c) || ((c >= `WAC_CH_A) && (c <= `WAC_CH_F));
  endfunction

  function automatic logic [7:0] dig_chr(input logic [3:0] v);
    dig_chr = `WAC_CH_ZERO | {4'h0, v};
  endfunction

  function automatic logic is_percode(input logic [7:0] n);
    is_percode = (n >= `WAC_PERCODE_LO) && (n <= `WAC_PERCODE_HI);
  endfunction

  // results buffer, popped when a reply with its head entry is built
  wac_acc_buf #(
    .DEPTH(ACC_DEPTH)
  ) u_buf (
    .clk(clk),
    .sys_rst(sys_rst),
    .push(acc_push),
    .push_code(acc_push_code),
    .push_neg(acc_push_neg),
    .push_bcd(acc_push_bcd),
    .pop(acc_pop),
    .head_code(head_code),
    .head_neg(head_neg),
    .head_bcd(head_bcd),
    .empty(acc_empty),
    .full(acc_full)
  );

  // receiver is held off while a command is in progress, not buffered
  assign rx_ready = (q.st == ST_IDLE);
  assign tx_valid = (q.st == ST_SEND);
  assign tx_data = q.txb[0];
  assign set_rd_num = q.set_rd_num;
  assign set_wr_en = q.set_wr_en;
  assign set_wr_num = q.set_wr_num;
  assign set_wr_bcd = q.set_wr_bcd;
  assign act_pulse = q.act_pulse;
  assign act_code = q.act_code;
  assign clr_pulse = q.clr_pulse;
  assign cal_start = q.cal_start;
  assign cal_span = q.cal_span;

  // line collection, decode on terminator, reply assembly and transmit
  always_comb begin
    logic [`WAC_TXB_LEN-1:0][7:0] b;
    logic [4:0][7:0] pre;
    logic [35:0] numbcd;
    logic [7:0] c0;
    logic [7:0] c1;
    logic [7:0] wnum;
    logic [3:0] cst;
    int n;
    int npre;
    int nd;
    int dp;
    logic mk;
    b = '0;
    pre = '0;
    numbcd = '0;
    c0 = q.line[0];
    c1 = q.line[1];
    wnum = {hex_val(q.line[1]), hex_val(q.line[2])};
    cst = (cal_status > `WAC_CAL_MAX) ? `WAC_CAL_MAX : cal_status;
    n = 0;
    npre = 0;
    nd = 0;
    dp = 0;
    mk = 1'b0;
    d = q;
    d.set_wr_en = 1'b0;
    d.act_pulse = 1'b0;
    d.clr_pulse = 1'b0;
    d.cal_start = 1'b0;
    acc_pop = 1'b0;
    case (q.st)
      ST_IDLE: begin
        if (rx_valid && rx_data == `WAC_CH_CR) begin
          d.lcnt = 4'h0;
          d.lovf = 1'b0;
          // nothing is acted on before the terminator; overlong lines are dropped [RULE16]
          if (!q.lovf && q.lcnt == `WAC_LEN_SHORT && c0 == `WAC_LEAD_READ) begin
            case (c1)
              `WAC_GROSS_READ: begin
                mk = 1'b1;
                pre[0] = gross_neg ? `WAC_CH_MINUS : `WAC_CH_PLUS; // [RULE1]
                npre = 1;
                numbcd = {16'h0000, gross_bcd};
                nd = 5;
                dp = int'(gross_dp);
              end
              `WAC_COUNT_READ: begin
                mk = 1'b1;
                pre[0] = c0; // [RULE2]
                pre[1] = c1;
                npre = 2;
                numbcd = {20'h00000, count_bcd};
                nd = 4;
              end
              `WAC_ACCV_READ: begin
                mk = 1'b1;
                pre[0] = c0; // [RULE3]
                pre[1] = c1;
                npre = 2;
                numbcd = accv_bcd;
                nd = 9;
                dp = int'(accv_dp);
              end
              `WAC_ACCW_READ: begin
                // an empty buffer answers code 00 and +00000 with the point set by gross_dp [RULE10]
                mk = 1'b1;
                pre[0] = c0;
                pre[1] = c1;
                pre[2] = acc_empty ? `WAC_CH_ZERO : dig_chr(head_code[7:4]);
                pre[3] = acc_empty ? `WAC_CH_ZERO : dig_chr(head_code[3:0]);
                pre[4] = (head_neg && !acc_empty) ? `WAC_CH_MINUS : `WAC_CH_PLUS;
                npre = 5;
                numbcd = acc_empty ? 36'h0 : {16'h0000, head_bcd};
                nd = 5;
                dp = int'(gross_dp);
                acc_pop = !acc_empty; // [RULE11]
              end
              default: begin
              end
            endcase
          end else if (!q.lovf && q.lcnt == `WAC_LEN_SHORT && c0 == `WAC_LEAD_CMD) begin
            if (c1 == `WAC_ZERO_CAL || c1 == `WAC_SPAN_CAL) begin
              // span accuracy depends on the host having set scale data first [RULE9]
              d.cal_start = 1'b1; // [RULE7]
              d.cal_span = (c1 == `WAC_SPAN_CAL);
              d.st = ST_CAL;
            end else if (c1 == `WAC_CLEAR_ACCUM) begin
              d.clr_pulse = 1'b1; // [RULE12]
            end else if (c1 >= `WAC_CH_A && c1 <= `WAC_CH_Z) begin
              d.act_pulse = 1'b1; // [RULE6]
              d.act_code = c1;
            end
          end else if (!q.lovf && q.lcnt == `WAC_LEN_SET_RD && c0 == `WAC_LEAD_WRITE
                       && is_hex(q.line[1]) && is_hex(q.line[2])) begin
            d.set_rd_num = wnum; // [RULE4]
            d.st = ST_RDSET;
          end else if (!q.lovf && q.lcnt == `WAC_LEN_SET_WR && c0 == `WAC_LEAD_WRITE
                       && is_hex(q.line[1]) && is_hex(q.line[2])
                       && is_digit(q.line[3]) && is_digit(q.line[4])
                       && is_digit(q.line[5]) && is_digit(q.line[6])
                       && is_digit(q.line[7])) begin
            // locked or unselected per-code writes are dropped silently [RULE15] [RULE14]
            if (!soft_lock && (!is_percode(wnum) || percode_en)) begin
              d.set_wr_en = 1'b1; // [RULE5]
              d.set_wr_num = wnum;
              d.set_wr_bcd = {q.line[3][3:0], q.line[4][3:0], q.line[5][3:0],
                              q.line[6][3:0], q.line[7][3:0]};
            end
          end
        end else if (rx_valid && rx_data != `WAC_CH_LF) begin
          if (q.lcnt == `WAC_LINE_MAX) begin
            d.lovf = 1'b1;
          end else begin
            d.line[q.lcnt[2:0]] = rx_data;
            d.lcnt = q.lcnt + 4'h1;
          end
        end
      end
      ST_RDSET: begin
        // setting table answers in the same cycle the number is presented
        mk = 1'b1;
        pre[0] = `WAC_LEAD_WRITE; // [RULE4]
        pre[1] = q.line[1];
        pre[2] = q.line[2];
        npre = 3;
        numbcd = {16'h0000, set_rd_bcd};
        nd = 5;
      end
      ST_CAL: begin
        if (cal_done) begin
          mk = 1'b1;
          pre[0] = `WAC_LEAD_CMD; // [RULE7]
          pre[1] = q.cal_span ? `WAC_SPAN_CAL : `WAC_ZERO_CAL;
          pre[2] = dig_chr(cst); // [RULE8]
          npre = 3;
        end
      end
      ST_SEND: begin
        if (tx_ready) begin
          d.txb = q.txb >> 8;
          d.tleft = q.tleft - 5'h01;
          if (q.tleft == 5'h01) begin
            d.st = ST_IDLE;
          end
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
    // shared reply assembly: prefix, digits with optional point, terminator
    if (mk) begin
      for (int i = 0; i < 5; i++) begin
        if (i < npre) begin
          b[n] = pre[i];
          n = n + 1;
        end
      end
      for (int i = 8; i >= 0; i--) begin
        if (i < nd) begin
          b[n] = dig_chr(numbcd[i*4+:4]);
          n = n + 1;
          if (dp != 0 && i == dp) begin
            b[n] = `WAC_CH_DOT;
            n = n + 1;
          end
        end
      end
      b[n] = `WAC_CH_CR; // [RULE17]
      b[n+1] = `WAC_CH_LF;
      d.txb = b;
      d.tleft = 5'(n + 2);
      d.st = ST_SEND;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // checked on the last two characters still queued, so back-pressure cannot fool it
  a_reply_ends_lf: assert property (@(posedge clk) disable iff (sys_rst) // [RULE17]
    (tx_valid && q.tleft == 5'h02) |-> tx_data == `WAC_CH_CR
      && q.txb[1] == `WAC_CH_LF)
    else $error("reply does not end with CR LF");

  a_decode_on_cr: assert property (@(posedge clk) disable iff (sys_rst) // [RULE16]
    (q.st == ST_IDLE ##1 q.st != ST_IDLE) |-> $past(rx_valid)
      && $past(rx_data) == `WAC_CH_CR)
    else $error("decode started without a terminator");

  a_lock_blocks_write: assert property (@(posedge clk) disable iff (sys_rst) // [RULE15]
    set_wr_en |-> $past(!soft_lock))
    else $error("setting written while locked");

  a_percode_gate: assert property (@(posedge clk) disable iff (sys_rst) // [RULE14]
    (set_wr_en && is_percode(set_wr_num)) |-> $past(percode_en))
    else $error("per-code setting written while selection disabled");

  a_write_silent: assert property (@(posedge clk) disable iff (sys_rst) // [RULE5]
    set_wr_en |-> !tx_valid ##1 !tx_valid)
    else $error("setting write produced a reply");

  a_action_silent: assert property (@(posedge clk) disable iff (sys_rst) // [RULE6]
    (act_pulse || clr_pulse) |-> !tx_valid ##1 !tx_valid ##1 !tx_valid)
    else $error("action or clear command produced a reply");

  a_cal_status_digit: assert property (@(posedge clk) disable iff (sys_rst) // [RULE8]
    (q.st == ST_CAL && cal_done) |=> tx_valid && q.tleft == 5'h05 && q.txb[2] ==
      (($past(cal_status) > `WAC_CAL_MAX) ? `WAC_CH_NINE : dig_chr($past(cal_status))))
    else $error("calibration reply digit wrong");

  a_count_reply: assert property (@(posedge clk) disable iff (sys_rst) // [RULE2]
    (q.st == ST_IDLE && rx_valid && rx_data == `WAC_CH_CR && !q.lovf
      && q.lcnt == `WAC_LEN_SHORT && q.line[0] == `WAC_LEAD_READ
      && q.line[1] == `WAC_COUNT_READ) |=> q.tleft == 5'h08
      && tx_data == `WAC_LEAD_READ && q.txb[2] == dig_chr($past(count_bcd[15:12])))
    else $error("count reply malformed");

  a_gross_len: assert property (@(posedge clk) disable iff (sys_rst) // [RULE1]
    (q.st == ST_IDLE && rx_valid && rx_data == `WAC_CH_CR && !q.lovf
      && q.lcnt == `WAC_LEN_SHORT && q.line[0] == `WAC_LEAD_READ
      && q.line[1] == `WAC_GROSS_READ && gross_dp != 3'h0 && gross_dp < 3'h5)
      |=> q.tleft == 5'h09)
    else $error("gross reply length wrong");
endmodule

// ### core/wac_pkg.sv
// types shared by the command interpreter files
`include "wac_cfg.svh"
package wac_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_RDSET, ST_CAL, ST_SEND} wac_state_e;

  typedef struct packed {
    wac_state_e st;
    logic [`WAC_LINE_MAX-1:0][7:0] line;
    logic [3:0] lcnt;
    logic lovf;
    logic [`WAC_TXB_LEN-1:0][7:0] txb;
    logic [4:0] tleft;
    logic cal_span;
    logic cal_start;
    logic set_wr_en;
    logic [7:0] set_wr_num;
    logic [19:0] set_wr_bcd;
    logic [7:0] set_rd_num;
    logic act_pulse;
    logic [7:0] act_code;
    logic clr_pulse;
  } wac_core_s;

  typedef struct packed {
    logic [8:0] wp;
    logic [8:0] rp;
    logic [9:0] cnt;
  } wac_buf_s;
endpackage

// ### verif/tb_wac_cmd.sv
// self-checking bench of the ascii command interpreter
`timescale 1ns/10ps
module tb_wac_cmd;
  logic clk, sys_rst, rx_valid, rx_ready, tx_valid, tx_ready, gross_neg, set_wr_en;
  logic soft_lock, percode_en, act_pulse, clr_pulse, cal_start, cal_span, cal_done;
  logic acc_push, acc_push_neg, acc_full;
  logic [7:0] rx_data, tx_data, set_rd_num, set_wr_num, act_code, acc_push_code;
  logic [19:0] gross_bcd, set_rd_bcd, set_wr_bcd, acc_push_bcd;
  logic [2:0] gross_dp;
  logic [15:0] count_bcd;
  logic [35:0] accv_bcd;
  logic [3:0] accv_dp, cal_status;
  integer seed = 52120;
  int n_mismatch = 0, n_tests = 0, n_wr = 0, n_act = 0, n_clr = 0, cyc = 0, cc = 0;
  logic cs;
  logic [28:0] mq[$];

  wac_cmd #(.ACC_DEPTH(4)) i_wac_cmd (
    .clk, .sys_rst, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready,
    .gross_neg, .gross_bcd, .gross_dp, .count_bcd, .accv_bcd, .accv_dp,
    .set_rd_num, .set_rd_bcd, .set_wr_en, .set_wr_num, .set_wr_bcd, .soft_lock,
    .percode_en, .act_pulse, .act_code, .clr_pulse, .cal_start, .cal_span,
    .cal_done, .cal_status, .acc_push, .acc_push_code, .acc_push_neg,
    .acc_push_bcd, .acc_full
  );

  wac_host i_wac_host (
    .clk, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // pulse counters sampled mid-cycle, away from the launching edge
  always @(negedge clk) begin
    n_wr += set_wr_en;
    n_act += act_pulse;
    n_clr += clr_pulse;
    cs = cal_start;
  end

  // calibration engine stand-in: done a few cycles after start
  always @(posedge clk) begin
    cal_done <= (cc == 1);
    if (cc > 0) cc <= cc - 1;
    else if (cs) cc <= 5;
  end

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      finish_test();
    end
  end

  function automatic logic [35:0] rb(int n);
    logic [35:0] v = '0;
    for (int i = 0; i < n; i++) v[4*i+:4] = 4'($unsigned($random(seed)) % 10);
    return v;
  endfunction

  // ascii digits msd first, point left of the last dp digits
  function automatic string dg(logic [35:0] v, int n, int dp);
    string s = "";
    for (int i = n - 1; i >= 0; i--) begin
      s = $sformatf("%s%c", s, 8'h30 + v[4*i+:4]);
      if (dp != 0 && i == dp) s = {s, "."};
    end
    return s;
  endfunction

  task automatic chk(logic [63:0] s, logic [63:0] e);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, s, e);
    end
  endtask

  // send one terminated line, wait for idle, compare the whole reply
  task automatic run(string c, string e);
    i_wac_host.rq.delete();
    i_wac_host.send({c, "\r"});
    repeat (3) @(posedge clk);
    for (int k = 0; k < 300; k++) begin
      @(negedge clk);
      if (rx_ready && !tx_valid) break;
    end
    @(posedge clk);
    chk(i_wac_host.rq.size(), e.len());
    foreach (i_wac_host.rq[i]) chk(i_wac_host.rq[i], e[i]);
  endtask

  task automatic push(logic [28:0] e);
    acc_push <= 1'b1;
    {acc_push_code, acc_push_neg, acc_push_bcd} <= e;
    @(posedge clk);
    acc_push <= 1'b0;
    if (mq.size() < 4) mq.push_back(e); // results beyond depth are dropped
    @(posedge clk);
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    logic [35:0] v;
    logic ng;
    logic [28:0] e;
    string c, x, sg;
    int n0;
    sys_rst = 1'b1;
    {gross_neg, gross_bcd, gross_dp, count_bcd, accv_bcd, accv_dp} = '0;
    {set_rd_bcd, soft_lock, percode_en, cal_done, cal_status} = '0;
    {acc_push, acc_push_code, acc_push_neg, acc_push_bcd} = '0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    i_wac_host.stall = 1;
    // no decode until the terminator arrives
    v = rb(4);
    count_bcd <= v[15:0];
    i_wac_host.send("RH");
    repeat (6) @(posedge clk);
    chk(i_wac_host.rq.size(), 0);
    run("", {"RH", dg(v, 4, 0), "\r\n"});
    // gross read across every point position
    for (int d = 0; d < 5; d++) begin
      v = rb(5);
      ng = 1'($random(seed));
      sg = ng ? "-" : "+";
      gross_bcd <= v[19:0];
      gross_neg <= ng;
      gross_dp <= 3'(d);
      run("RA", {sg, dg(v, 5, d), "\r\n"});
    end
    for (int d = 0; d < 9; d += 4) begin
      v = rb(9);
      accv_bcd <= v;
      accv_dp <= 4'(d);
      run("RI", {"RI", dg(v, 9, d), "\r\n"});
    end
    // setting read back by number
    v = rb(5);
    set_rd_bcd <= v[19:0];
    run("W2A", {"W2A", dg(v, 5, 0), "\r\n"});
    chk(set_rd_num, 8'h2A);
    // writes: plain, locked, per-code disabled then enabled
    n0 = n_wr;
    run("W5112345", "");
    chk(n_wr, n0 + 1);
    chk({set_wr_num, set_wr_bcd}, {8'h51, 20'h12345});
    soft_lock <= 1'b1;
    run("W5167890", "");
    chk(n_wr, n0 + 1);
    chk(set_wr_bcd, 20'h12345);
    soft_lock <= 1'b0;
    run("W2054321", "");
    chk(n_wr, n0 + 1);
    percode_en <= 1'b1; // host enables per-code selection first
    run("W2054321", "");
    chk(n_wr, n0 + 2);
    chk({set_wr_num, set_wr_bcd}, {8'h20, 20'h54321});
    // one-shot actions
    for (int k = 0; k < 4; k++) begin
      x = string'("DEFZ") ;
      c = {"C", x.substr(k, k)};
      run(c, "");
      chk(n_act, k + 1);
      chk(act_code, c[1]);
    end
    run("CK", "");
    chk(n_clr, 1);
    // calibration: ok, error, out of range; the error case runs span
    for (int k = 0; k < 3; k++) begin
      cal_status <= 4'(k * 6);
      c = (k == 1) ? "CB" : "CA";
      x = $sformatf("%0d", (k * 6 > 9) ? 9 : k * 6);
      run(c, {c, x, "\r\n"});
      chk(cal_span, k == 1);
    end
    // result buffer: overfill, then drain past empty
    gross_dp <= 3'h2;
    for (int k = 0; k < 5; k++) begin
      v = rb(7);
      ng = 1'($random(seed));
      push({v[27:20], ng, v[19:0]});
    end
    @(negedge clk);
    chk(acc_full, 1'b1);
    @(posedge clk);
    for (int k = 0; k < 5; k++) begin
      if (mq.size() > 0) begin
        e = mq.pop_front(); // read discards oldest
        sg = e[20] ? "-" : "+";
        run("RJ", {"RJ", dg(e[28:21], 2, 0), sg, dg(e[19:0], 5, 2), "\r\n"});
      end else begin
        run("RJ", {"RJ00+", dg(36'h0, 5, 2), "\r\n"});
      end
    end
    finish_test();
  end
endmodule

// ### verif/wac_host.sv
// host model: sends command lines and sinks reply characters
`timescale 1ns/10ps
module wac_host (
  input wire logic clk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  byte rq[$];
  integer seed = 52120;
  bit stall = 0;
  logic r;

  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
  end

  // one character per taken handshake; lines carry their own terminator
  task automatic send(string s);
    for (int i = 0; i < s.len(); i++) begin
      rx_valid <= 1'b1;
      rx_data <= s[i];
      do begin
        @(negedge clk) r = rx_ready;
        @(posedge clk);
      end while (!r);
    end
    rx_valid <= 1'b0;
    rx_data <= ~rx_data; // released data never keeps the old char
  endtask

  // sink samples mid-cycle so the take at the next edge is race free
  always @(negedge clk) begin
    if (tx_valid && tx_ready) rq.push_back(tx_data);
  end

  // random back-pressure when enabled
  always @(posedge clk) begin
    tx_ready <= stall ? ($random(seed) % 3 != 0) : 1'b1;
  end
endmodule
